//--- viu_map.vh
// Register offsets, field positions and reset values of the interrupt status/command block
`ifndef VIU_MAP_VH
`define VIU_MAP_VH
// Register byte offsets
`define VIU_OFF_NVEC      12'h100
`define VIU_OFF_FVEC      12'h104
`define VIU_OFF_CUR_SRC   12'h108
`define VIU_OFF_PENDING   12'h10c
`define VIU_OFF_ENABLED   12'h110
`define VIU_OFF_LINE_STAT 12'h114
`define VIU_OFF_EN_CMD    12'h120
`define VIU_OFF_DIS_CMD   12'h124
`define VIU_OFF_CLR_CMD   12'h128
`define VIU_OFF_SET_CMD   12'h12c
`define VIU_OFF_EOS_CMD   12'h130
`define VIU_OFF_SPUR      12'h134
`define VIU_OFF_DBG       12'h138
`define VIU_OFF_FF_EN     12'h140
`define VIU_OFF_FF_DIS    12'h144
`define VIU_OFF_FF_STAT   12'h148
`define VIU_OFF_SVEC_BASE 12'h080
`define VIU_OFF_SVEC_TOP  12'h0fc
`define VIU_OFF_IRQ_STAT  12'h150
`define VIU_OFF_IRQ_EN    12'h154
`define VIU_OFF_IRQ_CLR   12'h158
// Field positions
`define VIU_DBG_GUARD_BIT 0
`define VIU_DBG_GMASK_BIT 1
`define VIU_LINE_FAST_BIT 0
`define VIU_LINE_NORM_BIT 1
`define VIU_SRC_FAST      5'h00
// Reset values
`define VIU_RST_WORD      32'h0000_0000
`define VIU_RST_SRC       5'h00
`endif

//--- viu_vec_mem.v
// Vector table memory of 32 handler addresses with registered read data
`timescale 1ns/1ps
`default_nettype none
module viu_vec_mem #(
  parameter AW = 5,
  parameter DW = 32
) (
  input  wire          mclk,
  input  wire          ce,
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [DW-1:0] wdata,
  input  wire [AW-1:0] raddr,
  output reg  [DW-1:0] rdata_q
);
  reg [DW-1:0] mem [0:(1<<AW)-1]; // Handler table

  // Write port and registered read port
  always @(posedge mclk) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata_q <= mem[raddr];
    end
  end
endmodule
`default_nettype wire

//--- viu_regs.v
// Status and command register set of a 32-source vectored interrupt unit
//
// Function
// R1: Current source register shows serviced source number
// R2: Pending register, one bit per source
// R3: Enabled register shows per-source enable state
// R4: Line status: fast bit0, normal bit1
// R5: Enable command sets enables for ones
// R6: Disable command clears enables for ones
// R7: Clear command clears pending for ones
// R8: Set command forces pending for ones
// R9: Any end-of-service write signals end
// R10: Spurious vector read/write, returned when spurious
// R11: Debug bit0 is guard mode, resets zero
// R12: Global mask bit1 holds both lines inactive
// R13: Fast force enable for sources 1-31
// R14: Fast force disable for written ones
// R15: Fast force status shows bits 1-31
// R16: Wake still raised under global mask
// R17: Normal vector read returns current handler address
// R18: Command register reads return zero, no effect
`timescale 1ns/1ps
`default_nettype none
`include "viu_map.vh"
module viu_regs #(
  parameter NSRC = 32
) (
  input  wire            mclk,
  input  wire            rst,
  input  wire            ce,
  input  wire [11:0]     addr,
  input  wire [31:0]     wdata,
  input  wire            wr,
  input  wire            rd,
  output wire [31:0]     rdata_q,
  input  wire [NSRC-1:0] src_req,
  input  wire            core_idle,
  output wire            core_fast_request_line_n,
  output wire            core_normal_request_line_n,
  output wire            wake,
  output wire            end_of_service,
  output wire            access_guard_mode,
  output wire            irq
);
  // Synchronised source requests
  reg [NSRC-1:0] src_s1_q;          // First stage
  reg [NSRC-1:0] src_s2_q;          // Second stage
  reg [NSRC-1:0] src_d1_q;          // Previous for edge find
  reg            idle_s1_q;         // Idle first stage
  reg            idle_s2_q;         // Idle second stage
  // Programmer-visible state
  reg [NSRC-1:0] pending_q;         // Pending per source
  reg [NSRC-1:0] enabled_q;         // Enable per source
  reg [NSRC-1:0] ffs_q;             // Fast forcing per source
  reg [31:0]     spur_q;            // Spurious handler address
  reg            guard_q;           // Protection mode
  reg            gmask_q;           // Global line mask
  reg [4:0]      cur_src_q;         // Current source number
  reg            in_service_q;      // A normal interrupt is current
  reg            fast_line_q;       // Fast line active
  reg            norm_line_q;       // Normal line active
  reg [2:0]      ev_stat_q;         // Sticky event status
  reg [2:0]      ev_en_q;           // Event enables
  reg            vec_rd_q;          // Vector read pending data
  reg            vec_spur_q;        // Vector read is spurious
  reg [31:0]     word_q;            // Registered plain read word
  // Decodes
  wire wr_en   = ce & wr & (addr == `VIU_OFF_EN_CMD);
  wire wr_dis  = ce & wr & (addr == `VIU_OFF_DIS_CMD);
  wire wr_clr  = ce & wr & (addr == `VIU_OFF_CLR_CMD);
  wire wr_set  = ce & wr & (addr == `VIU_OFF_SET_CMD);
  wire wr_eos  = ce & wr & (addr == `VIU_OFF_EOS_CMD);
  wire wr_ffe  = ce & wr & (addr == `VIU_OFF_FF_EN);
  wire wr_ffd  = ce & wr & (addr == `VIU_OFF_FF_DIS);
  wire wr_svec = ce & wr & (addr >= `VIU_OFF_SVEC_BASE) & (addr <= `VIU_OFF_SVEC_TOP)
                 & (addr[1:0] == 2'b00);
  wire rd_nvec = ce & rd & (addr == `VIU_OFF_NVEC);
  wire rd_fvec = ce & rd & (addr == `VIU_OFF_FVEC);
  // Source edges and request sets
  wire [NSRC-1:0] src_rise = src_s2_q & ~src_d1_q;
  wire [NSRC-1:0] set_bits = src_rise | (wr_set ? wdata[NSRC-1:0] : {NSRC{1'b0}}); // R8
  wire [NSRC-1:0] clr_bits = wr_clr ? wdata[NSRC-1:0] : {NSRC{1'b0}};              // R7
  // Active requests split fast and normal
  wire [NSRC-1:0] act      = pending_q & enabled_q;
  wire [NSRC-1:0] fast_map = ffs_q | {{(NSRC-1){1'b0}}, 1'b1};
  wire            fast_req = |(act & fast_map);
  wire [NSRC-1:0] norm_act = act & ~fast_map;
  // Lowest-numbered normal request
  reg  [4:0] norm_id;
  reg        norm_any;
  integer    i;

  // Pick lowest active normal source
  always @* begin
    norm_id  = 5'h00;
    norm_any = 1'b0;
    for (i = NSRC-1; i >= 0; i = i - 1) begin
      if (norm_act[i]) begin
        norm_id  = i[4:0];
        norm_any = 1'b1;
      end
    end
  end

  // Vector table, looked up by fast source 0, current source or lowest normal request
  wire [31:0] vec_rdata;
  wire [4:0]  vec_raddr = rd_fvec ? `VIU_SRC_FAST : (in_service_q ? cur_src_q : norm_id);
  viu_vec_mem #(.AW(5), .DW(32)) u_vec (
    .mclk    (mclk),
    .ce      (ce),
    .we      (wr_svec),
    .waddr   (addr[6:2]),
    .wdata   (wdata),
    .raddr   (vec_raddr),
    .rdata_q (vec_rdata)
  );

  // Input synchronisers
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      src_s1_q  <= {NSRC{1'b0}};
      src_s2_q  <= {NSRC{1'b0}};
      src_d1_q  <= {NSRC{1'b0}};
      idle_s1_q <= 1'b0;
      idle_s2_q <= 1'b0;
    end else if (ce) begin
      src_s1_q  <= src_req;
      src_s2_q  <= src_s1_q;
      src_d1_q  <= src_s2_q;
      idle_s1_q <= core_idle;
      idle_s2_q <= idle_s1_q;
    end
  end

  // Pending, enable and fast forcing state
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      pending_q <= {NSRC{1'b0}};
      enabled_q <= {NSRC{1'b0}};
      ffs_q     <= {NSRC{1'b0}};
    end else if (ce) begin
      // Hardware set wins over software clear
      pending_q <= (pending_q & ~clr_bits) | set_bits; // R2 R7 R8
      if (wr_en) begin
        enabled_q <= enabled_q | wdata[NSRC-1:0]; // R5
      end else if (wr_dis) begin
        enabled_q <= enabled_q & ~wdata[NSRC-1:0]; // R6
      end
      if (wr_ffe) begin
        ffs_q <= ffs_q | {wdata[NSRC-1:1], 1'b0}; // R13
      end else if (wr_ffd) begin
        ffs_q <= ffs_q & ~{wdata[NSRC-1:1], 1'b0}; // R14
      end
    end
  end

  // Current source tracking and end of service
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cur_src_q    <= `VIU_RST_SRC;
      in_service_q <= 1'b0;
    end else if (ce) begin
      if (wr_eos) begin
        in_service_q <= 1'b0; // R9
      end else if (rd_nvec && !in_service_q && norm_any) begin
        cur_src_q    <= norm_id; // R1
        in_service_q <= 1'b1;
      end
    end
  end

  // Control registers and line state
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      spur_q      <= `VIU_RST_WORD;
      guard_q     <= 1'b0;
      gmask_q     <= 1'b0;
      fast_line_q <= 1'b0;
      norm_line_q <= 1'b0;
    end else if (ce) begin
      if (wr && addr == `VIU_OFF_SPUR) begin
        spur_q <= wdata; // R10
      end
      if (wr && addr == `VIU_OFF_DBG) begin
        guard_q <= wdata[`VIU_DBG_GUARD_BIT]; // R11
        gmask_q <= wdata[`VIU_DBG_GMASK_BIT];
      end
      fast_line_q <= fast_req & ~gmask_q;              // R12
      norm_line_q <= norm_any & ~in_service_q & ~gmask_q; // R12
    end
  end

  // Sticky event status with enable and clear
  wire [2:0] ev_set = {wr_eos, |src_rise, fast_req & ~fast_line_q & ~gmask_q};
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      ev_stat_q <= 3'h0;
      ev_en_q   <= 3'h0;
    end else if (ce) begin
      if (wr && addr == `VIU_OFF_IRQ_EN) begin
        ev_en_q <= wdata[2:0];
      end
      // Set wins over clear
      ev_stat_q <= (ev_stat_q & ~((wr && addr == `VIU_OFF_IRQ_CLR) ? wdata[2:0] : 3'h0))
                   | ev_set;
    end
  end

  // Read data mux, registered; vector reads resolve after the table
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      word_q     <= `VIU_RST_WORD;
      vec_rd_q   <= 1'b0;
      vec_spur_q <= 1'b0;
    end else if (ce) begin
      vec_rd_q   <= 1'b0;
      vec_spur_q <= 1'b0;
      word_q     <= `VIU_RST_WORD;
      if (rd) begin
        case (addr)
          `VIU_OFF_CUR_SRC:   word_q <= {27'h0, cur_src_q};            // R1
          `VIU_OFF_PENDING:   word_q <= pending_q;                     // R2
          `VIU_OFF_ENABLED:   word_q <= enabled_q;                     // R3
          `VIU_OFF_LINE_STAT: word_q <= {30'h0, norm_line_q, fast_line_q}; // R4
          `VIU_OFF_SPUR:      word_q <= spur_q;
          `VIU_OFF_DBG:       word_q <= {30'h0, gmask_q, guard_q};
          `VIU_OFF_FF_STAT:   word_q <= {ffs_q[NSRC-1:1], 1'b0};       // R15
          `VIU_OFF_IRQ_STAT:  word_q <= {29'h0, ev_stat_q};
          `VIU_OFF_IRQ_EN:    word_q <= {29'h0, ev_en_q};
          `VIU_OFF_NVEC: begin
            vec_rd_q   <= 1'b1;
            vec_spur_q <= ~in_service_q & ~norm_any; // R17
          end
          `VIU_OFF_FVEC: begin
            vec_rd_q   <= 1'b1;
            vec_spur_q <= ~fast_req; // R10
          end
          // Command and unmapped offsets read zero
          default:            word_q <= `VIU_RST_WORD; // R18
        endcase
      end
    end
  end

  // Vector answers substitute table data
  wire [31:0] vec_word = vec_spur_q ? spur_q : vec_rdata;
  reg  [31:0] rdata_mux;
  always @* begin
    rdata_mux = vec_rd_q ? vec_word : word_q;
  end
  // Read data port carries vector answers too
  assign rdata_q = rdata_mux; // R17

  // Outputs; lines are active low
  assign core_fast_request_line_n   = ~fast_line_q;
  assign core_normal_request_line_n = ~norm_line_q;
  assign wake              = (|act) & idle_s2_q; // R16
  assign end_of_service    = wr_eos;             // R9
  assign access_guard_mode = guard_q;
  assign irq               = |(ev_stat_q & ev_en_q);
endmodule
`default_nettype wire

//--- viu_regs_assertions.sv
// Port checker for the interrupt status and command register block
`timescale 1ns/1ps
`default_nettype none
module viu_regs_chk (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata_q,
  input wire logic        core_fast_request_line_n,
  input wire logic        core_normal_request_line_n,
  input wire logic        end_of_service,
  input wire logic        access_guard_mode
);
  logic gm_q; // Shadow of the global line mask
  // Follow mask writes
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      gm_q <= 1'b0;
    end else if (ce && wr && addr == 12'h138) begin
      gm_q <= wdata[1];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_eos; ce && wr && addr == 12'h130 |-> end_of_service; endproperty
  a_eos: assert property (p_eos) else $error("end of service pulse missing");
  property p_cmd0; rd && addr inside {12'h120, 12'h124, 12'h128, 12'h12c, 12'h130,
    12'h140, 12'h144} |=> rdata_q == 32'h0; endproperty
  a_cmd0: assert property (p_cmd0) else $error("command read not zero");
  property p_cur; rd && addr == 12'h108 |=> rdata_q[31:5] == 27'h0; endproperty
  a_cur: assert property (p_cur) else $error("source number upper bits set");
  property p_guard; ce && wr && addr == 12'h138 |=> access_guard_mode == $past(wdata[0]);
  endproperty
  a_guard: assert property (p_guard) else $error("guard mode not taken");
  property p_gmask; gm_q && $past(gm_q) |-> core_fast_request_line_n && core_normal_request_line_n;
  endproperty
  a_gmask: assert property (p_gmask) else $error("line active under mask");
  property p_spur; wr && addr == 12'h134 ##1 !wr ##1 rd && addr == 12'h134
    |=> rdata_q == $past(wdata, 3); endproperty
  a_spur: assert property (p_spur) else $error("spurious vector readback wrong");
  property p_ffs0; rd && addr == 12'h148 |=> rdata_q[0] == 1'b0; endproperty
  a_ffs0: assert property (p_ffs0) else $error("fast force bit0 set");
  property p_line; rd && addr == 12'h114 |=> rdata_q == {30'h0,
    !$past(core_normal_request_line_n), !$past(core_fast_request_line_n)}; endproperty
  a_line: assert property (p_line) else $error("line status mismatch");
endmodule
`default_nettype wire

//--- viu_core_model.sv
// Behavioural processor core that sleeps on request and wakes on the wake line
`timescale 1ns/1ps
`default_nettype none
module viu_core_model (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic sleep,
  input  wire logic wake,
  output var  logic core_idle,
  output var  logic woke
);
  // Idle on request, leave idle when the unit asks for wake-up
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      core_idle <= 1'b0;
      woke      <= 1'b0;
    end else if (sleep) begin
      core_idle <= 1'b1;
    end else if (core_idle && wake) begin
      core_idle <= 1'b0;
      woke      <= 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- viu_regs_tb.sv
// Self-checking bench for the interrupt status and command register block
`timescale 1ns/1ps
`default_nettype none
module viu_regs_tb;
  logic        mclk, rst, ce, wr, rd, sleep;
  logic [11:0] addr;
  logic [31:0] wdata, src_req;
  wire  [31:0] rdata_q;
  wire         fq_n, nq_n, wake, eos, guard, irq, core_idle, woke;
  int          n_mismatch = 0;
  int          num_checks = 0;
  logic [87:0] tbl [0:8]; // Write address, data, read address, expected
  logic [11:0] rlist [0:7] = '{12'h108, 12'h10c, 12'h110, 12'h114, 12'h120, 12'h134,
    12'h138, 12'h148};
  viu_regs uut (.mclk(mclk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata_q(rdata_q), .src_req(src_req), .core_idle(core_idle), .wake(wake),
    .core_fast_request_line_n(fq_n), .core_normal_request_line_n(nq_n),
    .end_of_service(eos), .access_guard_mode(guard), .irq(irq));
  viu_core_model core (.mclk(mclk), .rst(rst), .sleep(sleep), .wake(wake),
    .core_idle(core_idle), .woke(woke));
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One-cycle register write
  task automatic wr_t(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  // One-cycle read, data checked in the following cycle
  task automatic rd_t(input logic [11:0] a, input logic [31:0] e, input string nm);
    @(posedge mclk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk(nm, rdata_q, e);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // Watchdog
  initial begin
    repeat (5000) @(posedge mclk);
    n_mismatch++;
    end_of_test;
  end
  // Main sequence
  initial begin
    {rst, ce} = 2'b11;
    {wr, rd, sleep, addr, wdata, src_req} = '0;
    tbl = '{{12'h120, 32'hffff_ffff, 12'h110, 32'hffff_ffff},
      {12'h124, 32'h0000_fff0, 12'h110, 32'hffff_000f}, {12'h12c, 32'h0000_00a0, 12'h10c,
      32'h0000_00a0}, {12'h128, 32'h0000_0020, 12'h10c, 32'h0000_0080}, {12'h140,
      32'hffff_ffff, 12'h148, 32'hffff_fffe}, {12'h144, 32'h0000_ff00, 12'h148, 32'hffff_00fe},
      {12'h134, 32'h1234_5678, 12'h134, 32'h1234_5678}, {12'h128, 32'h0000_0080, 12'h124,
      32'h0}, {12'h200, 32'hdead_beef, 12'h200, 32'h0}};
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      wr_t(tbl[i][87:76], tbl[i][75:44]);
      rd_t(tbl[i][43:32], tbl[i][31:0], "table row");
    end
    // Software-set fast source raises the fast line and the event interrupt
    wr_t(12'h154, 32'h5);
    wr_t(12'h12c, 32'h1);
    repeat (3) @(posedge mclk);
    rd_t(12'h114, 32'h1, "line status");
    rd_t(12'h10c, 32'h1, "pending fast");
    chk("irq raised", irq, 1'b1);
    wr_t(12'h158, 32'h1);
    #1;
    chk("irq cleared", irq, 1'b0);
    wr_t(12'h130, 32'hdead_beef);
    #1;
    chk("irq on eos", irq, 1'b1);
    wr_t(12'h154, 32'h0);
    #1;
    chk("irq masked", irq, 1'b0);
    // Global mask keeps lines quiet but still wakes the core
    wr_t(12'h138, 32'h3);
    repeat (2) @(posedge mclk);
    #1;
    chk("masked lines", {fq_n, nq_n, guard}, 3'b111);
    @(posedge mclk) sleep <= 1'b1;
    @(posedge mclk) sleep <= 1'b0;
    for (int i = 0; i < 10 && !woke; i++) @(posedge mclk);
    chk("wake", woke, 1'b1);
    // Source edge sets its pending bit
    wr_t(12'h128, 32'hffff_ffff);
    @(posedge mclk) src_req <= 32'h8;
    repeat (4) @(posedge mclk);
    rd_t(12'h10c, 32'h8, "source edge");
    // Vector reads: fast entry, spurious normal, then a serviced normal source
    wr_t(12'h080, 32'h0000_a000);
    rd_t(12'h104, 32'h0000_a000, "fast vector");
    rd_t(12'h100, 32'h1234_5678, "spurious vector");
    wr_t(12'h144, 32'h0000_0008);
    wr_t(12'h08c, 32'h0000_b000);
    rd_t(12'h100, 32'h0000_b000, "normal vector");
    rd_t(12'h108, 32'h0000_0003, "current source");
    wr_t(12'h130, 32'h0);
    // Second reset, then reset values
    @(posedge mclk) src_req <= 32'h0;
    @(posedge mclk) rst <= 1'b1;
    @(posedge mclk) rst <= 1'b0;
    #1;
    chk("guard reset", guard, 1'b0);
    foreach (rlist[i]) rd_t(rlist[i], 32'h0, "reset value");
    end_of_test;
  end
endmodule
bind viu_regs viu_regs_chk u_chk (.mclk(mclk), .rst(rst), .ce(ce), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q),
  .core_fast_request_line_n(core_fast_request_line_n),
  .core_normal_request_line_n(core_normal_request_line_n),
  .end_of_service(end_of_service), .access_guard_mode(access_guard_mode));
`default_nettype wire
